//--- include/aom_pkg.sv
package aom_pkg;
    // sample word width and conversion pipeline length
    localparam int WORD_W = 14;
    localparam int PIPE_DEPTH = 8;
    // select pin levels as delivered by the quad-level comparator
    localparam logic [1:0] SEL_GROUND = 2'h0;
    localparam logic [1:0] SEL_ONE_THIRD = 2'h1;
    localparam logic [1:0] SEL_TWO_THIRDS = 2'h2;
    localparam logic [1:0] SEL_SUPPLY = 2'h3;
    // timing: system clock rate and wake settling time
    localparam int CLK_MHZ = 125;
    localparam int SETTLE_TIME_US = 3000;
    localparam int SETTLE_CYC = SETTLE_TIME_US * CLK_MHZ;
    // sample clock cycles of blanking after a select change
    localparam int GUARD_CYC = 4;
    localparam int GUARD_W = 3;
    // clock duty range that the stabiliser accepts, in percent
    localparam int DUTY_MIN_PCT = 30;
    localparam int DUTY_MAX_PCT = 70;
    // register byte addresses
    localparam logic [7:0] ADDR_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [31:0] CONTROL_RESET = 32'h00000000;
    // control field positions
    localparam int CTL_SOFT_SLEEP = 0;
    localparam int CTL_OVR_EN = 1;
    localparam int CTL_OVR_SEL_LO = 2;
    localparam int CTL_W = 4;
    // status field positions
    localparam int STS_ASLEEP = 0;
    localparam int STS_DCS = 1;
    localparam int STS_TWOS = 2;
    localparam int STS_SEL_LO = 3;
    localparam int STS_SETTLED = 5;
    // axi response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- rtl/aom_pipe.sv
`timescale 1ns/100ps
module aom_pipe #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic flush,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data
);
    // one data word and one valid flag per stage
    logic [WIDTH-1:0] data_reg [DEPTH];
    logic [DEPTH-1:0] valid_reg;

    genvar i;
    generate
        for (i = 0; i < DEPTH; i = i + 1)
        begin : g_stage
            // what this stage takes: the input for the first, else the stage before;
            // a generate branch keeps the first stage from naming index -1
            logic [WIDTH-1:0] src_data;
            logic src_valid;
            if (i == 0)
            begin : g_first
                assign src_data = in_data;
                assign src_valid = in_valid;
            end
            else
            begin : g_next
                assign src_data = data_reg[i-1];
                assign src_valid = valid_reg[i-1];
            end
            // each stage after the first takes the previous one; flush drops every held sample
            always_ff @(posedge clk)
            begin
                if (flush)
                begin
                    valid_reg[i] <= 1'b0;
                    data_reg[i] <= '0;
                end
                else
                begin
                    valid_reg[i] <= src_valid;
                    data_reg[i] <= src_data;
                end
            end
        end
    endgenerate

    assign out_valid = valid_reg[DEPTH-1];
    assign out_data = data_reg[DEPTH-1];
endmodule

//--- rtl/aom_sync.sv
`timescale 1ns/100ps
module aom_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    // first stage is read only by the second stage
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] q_reg;

    // two flops in the destination domain
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            meta_reg <= '0;
            q_reg <= '0;
        end
        else
        begin
            meta_reg <= d;
            q_reg <= meta_reg;
        end
    end

    assign q = q_reg;
endmodule

//--- rtl/aom_top.sv
// Register access over AXI4-Lite and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
module aom_top
    import aom_pkg::*;
#(
    parameter int SETTLE_CYCLES = aom_pkg::SETTLE_CYC,
    parameter int PIPE_STAGES = aom_pkg::PIPE_DEPTH
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic clk_en,
    input wire logic sample_clk,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic sleep_request,
    input wire logic [1:0] format_stabiliser_select,
    input wire logic [aom_pkg::WORD_W-1:0] raw_code,
    output logic [aom_pkg::WORD_W-1:0] sample_word,
    output logic word_valid_strobe,
    output logic duty_stabiliser,
    output logic converter_active
);
    import aom_pkg::*;

    localparam int SCW = $clog2(SETTLE_CYCLES + 1);

    // system domain: pin sync, control and settling timer
    logic sleep_pin_s; // sleep pin after two flops
    logic [CTL_W-1:0] ctrl_reg; // software control bits
    logic [CTL_W-1:0] ctrl_next;
    logic sleep_sys_reg; // combined sleep demand
    logic [SCW-1:0] settle_cnt_reg; // cycles awake since wake
    logic settled_reg; // reference assumed recharged
    logic [4:0] status_s; // link state seen from system side

    // axi write side holding registers
    logic aw_full_reg;
    logic [7:0] aw_addr_reg;
    logic w_full_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    // axi read side
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;

    // link domain
    logic lrst; // reset carried into the sample clock domain
    logic [1:0] sel_pin_l; // select pin after two flops
    logic [2:0] ovr_l; // override enable and level, crossed
    logic sleep_l; // sleep demand, crossed
    logic settled_l; // settling done, crossed
    logic [1:0] sel_reg; // effective select, registered
    logic twos_reg; // twos complement active
    logic dcs_reg; // stabiliser active
    logic [GUARD_W-1:0] guard_reg; // blanking left after a change
    logic pipe_valid;
    logic [WORD_W-1:0] pipe_data;
    logic [WORD_W-1:0] word_reg;
    logic out_valid_reg;
    logic strobe_p_reg; // rising-edge half of the strobe
    logic strobe_n_reg; // falling-edge half of the strobe

    // decode and selection wires
    wire aw_take = s_axi_awvalid && !aw_full_reg;
    wire w_take = s_axi_wvalid && !w_full_reg;
    wire wr_fire = aw_full_reg && w_full_reg && !bvalid_reg;
    wire wr_ctrl = aw_addr_reg == ADDR_CONTROL;
    wire ar_take = s_axi_arvalid && !rvalid_reg;
    wire rd_ctrl = s_axi_araddr == ADDR_CONTROL;
    wire rd_stat = s_axi_araddr == ADDR_STATUS;
    wire [31:0] ctrl_word = {{(32 - CTL_W){1'b0}}, ctrl_reg};
    wire [31:0] stat_word = {{26{1'b0}}, settled_reg, status_s[4:0]};
    wire [31:0] rd_mux = rd_ctrl ? ctrl_word : (rd_stat ? stat_word : 32'h00000000);
    wire [1:0] sel_eff = ovr_l[0] ? ovr_l[2:1] : sel_pin_l;
    wire twos_w = (sel_eff == SEL_SUPPLY) || (sel_eff == SEL_TWO_THIRDS);
    wire dcs_w = (sel_eff == SEL_ONE_THIRD) || (sel_eff == SEL_TWO_THIRDS);
    wire sel_changed = sel_eff != sel_reg;
    wire guard_idle = guard_reg == '0;
    wire [WORD_W-1:0] fmt_word = twos_reg ? {~pipe_data[WORD_W-1], pipe_data[WORD_W-2:0]}
                                          : pipe_data;

    // pin that arrives from outside the system domain
    aom_sync #(
        .WIDTH(1)
    ) u_sleep_sync (
        .clk(clk),
        .rst(srst),
        .d(sleep_request),
        .q(sleep_pin_s)
    );

    // link state back to the system domain for the status register
    aom_sync #(
        .WIDTH(5)
    ) u_stat_sync (
        .clk(clk),
        .rst(srst),
        .d({sel_reg, twos_reg, dcs_reg, sleep_l}),
        .q(status_s)
    );

    // control byte write; only byte lane 0 carries bits
    always_comb
    begin
        ctrl_next = ctrl_reg;
        if (wr_fire && wr_ctrl && w_strb_reg[0])
        begin
            ctrl_next = w_data_reg[CTL_W-1:0];
        end
    end

    // write address and data are held independently, in either order
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            aw_full_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_full_reg <= 1'b0;
            w_data_reg <= 32'h00000000;
            w_strb_reg <= 4'h0;
        end
        else if (clk_en)
        begin
            if (aw_take)
            begin
                aw_full_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            else if (wr_fire)
            begin
                aw_full_reg <= 1'b0;
            end
            if (w_take)
            begin
                w_full_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            else if (wr_fire)
            begin
                w_full_reg <= 1'b0;
            end
        end
    end

    // write response; unmapped addresses answer slverr
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            ctrl_reg <= CONTROL_RESET[CTL_W-1:0];
        end
        else if (clk_en)
        begin
            ctrl_reg <= ctrl_next;
            if (wr_fire)
            begin
                bvalid_reg <= 1'b1;
                bresp_reg <= (wr_ctrl || aw_addr_reg == ADDR_STATUS) ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_bready)
            begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // read channel: data registered one cycle after the address is taken
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            rresp_reg <= RESP_OKAY;
        end
        else if (clk_en)
        begin
            if (ar_take)
            begin
                rvalid_reg <= 1'b1;
                rdata_reg <= rd_mux;
                rresp_reg <= (rd_ctrl || rd_stat) ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_rready)
            begin
                rvalid_reg <= 1'b0;
            end
        end
    end

    // wake timer: counts in the system domain because its clock is the one that
    // is known to be steady; it restarts from zero on every sleep
    // hold off after wake
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            sleep_sys_reg <= 1'b1;
            settle_cnt_reg <= '0;
            settled_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            sleep_sys_reg <= sleep_pin_s || ctrl_reg[CTL_SOFT_SLEEP];
            if (sleep_sys_reg)
            begin
                settle_cnt_reg <= '0;
                settled_reg <= 1'b0;
            end
            else if (settle_cnt_reg == SCW'(SETTLE_CYCLES))
            begin
                settled_reg <= 1'b1;
            end
            else
            begin
                settle_cnt_reg <= settle_cnt_reg + 1'b1;
            end
        end
    end

    // reset into the sample clock domain; its own flops carry no reset
    aom_sync #(
        .WIDTH(1)
    ) u_rst_sync (
        .clk(sample_clk),
        .rst(1'b0),
        .d(srst),
        .q(lrst)
    );

    // select pin straight from outside
    aom_sync #(
        .WIDTH(2)
    ) u_sel_sync (
        .clk(sample_clk),
        .rst(lrst),
        .d(format_stabiliser_select),
        .q(sel_pin_l)
    );

    // static control levels and timer state from the system domain; a torn
    // multi-bit override is covered by the change blanking below
    aom_sync #(
        .WIDTH(5)
    ) u_ctl_sync (
        .clk(sample_clk),
        .rst(lrst),
        .d({ctrl_reg[CTL_OVR_SEL_LO+1:CTL_OVR_SEL_LO], ctrl_reg[CTL_OVR_EN],
            sleep_sys_reg, settled_reg}),
        .q({ovr_l, sleep_l, settled_l})
    );

    // mode register and blanking after a select change
    always_ff @(posedge sample_clk)
    begin
        if (lrst)
        begin
            sel_reg <= SEL_GROUND;
            twos_reg <= 1'b0;
            dcs_reg <= 1'b0;
            guard_reg <= '0;
        end
        else
        begin
            sel_reg <= sel_eff;
            twos_reg <= twos_w;
            dcs_reg <= dcs_w;
            if (sel_changed)
            begin
                guard_reg <= GUARD_W'(GUARD_CYC);
            end
            else if (!guard_idle)
            begin
                guard_reg <= guard_reg - 1'b1;
            end
        end
    end

    // conversion pipeline; sleep flushes every held sample
    // pipeline lost in sleep
    aom_pipe #(
        .WIDTH(WORD_W),
        .DEPTH(PIPE_STAGES)
    ) u_pipe (
        .clk(sample_clk),
        .flush(lrst || sleep_l),
        .in_valid(!sleep_l),
        .in_data(raw_code),
        .out_valid(pipe_valid),
        .out_data(pipe_data)
    );

    // output word register; the word is zeroed in sleep so nothing stale leaks
    always_ff @(posedge sample_clk)
    begin
        if (lrst)
        begin
            word_reg <= '0;
            out_valid_reg <= 1'b0;
        end
        else if (sleep_l)
        begin
            word_reg <= '0;
            out_valid_reg <= 1'b0;
        end
        else
        begin
            if (pipe_valid)
            begin
                word_reg <= fmt_word;
            end
            out_valid_reg <= pipe_valid && settled_l && guard_idle;
        end
    end

    // strobe built from two edge flops: it falls at each rising sample clock edge
    // and rises at the falling edge for a valid word, so the receiver's rising
    // edge lands half a period after the data changed and no clock is gated
    // one strobe rise per word
    always_ff @(posedge sample_clk)
    begin
        if (lrst)
        begin
            strobe_p_reg <= 1'b0;
        end
        else
        begin
            strobe_p_reg <= strobe_n_reg;
        end
    end

    // falling-edge half of the strobe
    // data stable at strobe rise
    always_ff @(negedge sample_clk)
    begin
        if (lrst)
        begin
            strobe_n_reg <= 1'b0;
        end
        else
        begin
            strobe_n_reg <= strobe_p_reg ^ out_valid_reg;
        end
    end

    // bus outputs
    assign s_axi_awready = !aw_full_reg;
    assign s_axi_wready = !w_full_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    // converter pins
    // fourteen line word
    assign sample_word = word_reg;
    assign word_valid_strobe = strobe_p_reg ^ strobe_n_reg;
    assign duty_stabiliser = dcs_reg;
    assign converter_active = !sleep_l;
endmodule

//--- verif/adc_output_mode_powerdown_tb_top.sv
`timescale 1ns/100ps
module adc_output_mode_powerdown_tb_top;
    import aom_pkg::*;
    // short settling keeps the wake test brief
    localparam int SETTLE = 50;
    localparam logic [13:0] CODES [3] = '{14'h2000, 14'h0000, 14'h3FFF};
    logic clk = 1'b0, sample_clk = 1'b0, srst = 1'b1, clk_en = 1'b1, sleep_request = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [1:0] format_stabiliser_select = SEL_SUPPLY;
    logic [13:0] raw_code = 14'h0000, sample_word, held_word;
    logic word_valid_strobe, duty_stabiliser, converter_active;
    int word_count, num_errors = 0, n_checks = 0, c;

    always #4 clk = ~clk;
    initial
    begin
        #0.7;
        forever #3 sample_clk = ~sample_clk;
    end

    aom_top #(.SETTLE_CYCLES(SETTLE), .PIPE_STAGES(PIPE_DEPTH)) u_aom_top (
        .clk, .srst, .clk_en, .sample_clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sleep_request,
        .format_stabiliser_select, .raw_code, .sample_word, .word_valid_strobe,
        .duty_stabiliser, .converter_active
    );
    aom_capture_model u_aom_capture_model (.word_valid_strobe, .sample_word, .held_word,
        .word_count);

    // value comparison, four-state exact
    task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // address and data offered together, each dropped once taken
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (s_axi_awready === 1'b1)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1)
                s_axi_wvalid <= 1'b0;
        end
        while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        check_val("bvalid", 32'h1, 32'(s_axi_bvalid));
        check_val("bresp", 32'(er), 32'(s_axi_bresp));
    endtask

    // ready raised only once data shows, so the slave must hold it
    task automatic axi_read(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m,
        input logic [1:0] er);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do
        begin
            @(posedge clk);
            if (s_axi_arready === 1'b1)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1 && s_axi_rready !== 1'b1)
                s_axi_rready <= 1'b1;
        end
        while (!(s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1));
        s_axi_rready <= 1'b0;
        check_val("rdata", exp, s_axi_rdata & m);
        check_val("rresp", 32'(er), 32'(s_axi_rresp));
    endtask

    // hold one raw code past the pipeline, then look at the captured word
    task automatic word_check(input logic [13:0] v, input logic [13:0] exp);
        @(posedge sample_clk);
        raw_code <= v;
        repeat (PIPE_DEPTH + 6) @(posedge sample_clk);
        check_val("sample_word", 32'(exp), 32'(held_word));
    endtask

    // captured words over exactly 20 sample clocks
    task automatic count_words(output int n);
        int c0;
        c0 = word_count;
        repeat (20) @(posedge sample_clk);
        n = word_count - c0;
    endtask

    task automatic final_report;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // main sequence
    initial
    begin
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        axi_read(ADDR_CONTROL, CONTROL_RESET, 32'hFFFFFFFF, RESP_OKAY);
        axi_write(ADDR_CONTROL, 32'h0000000C, RESP_OKAY);
        axi_read(ADDR_CONTROL, 32'h0000000C, 32'hFFFFFFFF, RESP_OKAY);
        axi_write(ADDR_STATUS, 32'hFFFFFFFF, RESP_OKAY);
        axi_write(8'h08, 32'h00000001, RESP_SLVERR);
        axi_read(8'h08, 32'h00000000, 32'hFFFFFFFF, RESP_SLVERR);
        axi_write(ADDR_CONTROL, 32'h00000001, RESP_OKAY);
        repeat (10) @(posedge clk);
        axi_read(ADDR_STATUS, 32'h1 << STS_ASLEEP, 32'h1 << STS_ASLEEP, RESP_OKAY);
        axi_write(ADDR_CONTROL, 32'h0000000C, RESP_OKAY);
        // three frozen cycles must not lose register state
        clk_en <= 1'b0;
        repeat (3) @(posedge clk);
        clk_en <= 1'b1;
        axi_read(ADDR_CONTROL, 32'h0000000C, 32'hFFFFFFFF, RESP_OKAY);
        repeat (SETTLE + 40) @(posedge clk);
        // every select level, each a change from the last
        for (int s = 0; s < 4; s++)
        begin
            @(posedge sample_clk);
            format_stabiliser_select <= s[1:0];
            count_words(c);
            check_val("guard", 32'h1, 32'(c < 20));
            foreach (CODES[i])
                word_check(CODES[i], CODES[i] ^ {s[1], 13'h0000});
            check_val("dcs", 32'(s[0] ^ s[1]), 32'(duty_stabiliser));
            axi_read(ADDR_STATUS, (32'(s[1]) << STS_TWOS) | (32'(s[0] ^ s[1]) << STS_DCS)
                | (32'(s[1:0]) << STS_SEL_LO), (32'h1 << STS_TWOS) | (32'h1 << STS_DCS)
                | (32'h3 << STS_SEL_LO), RESP_OKAY);
        end
        count_words(c);
        check_val("rate", 32'd20, 32'(c));
        @(posedge clk);
        sleep_request <= 1'b1;
        repeat (20) @(posedge clk);
        check_val("active", 32'h0, 32'(converter_active));
        axi_read(ADDR_STATUS, 32'h1 << STS_ASLEEP,
            (32'h1 << STS_ASLEEP) | (32'h1 << STS_SETTLED), RESP_OKAY);
        count_words(c);
        check_val("sleep words", 32'h0, 32'(c));
        check_val("sleep word", 32'h0, 32'(sample_word));
        @(posedge clk);
        sleep_request <= 1'b0;
        count_words(c);
        check_val("settling words", 32'h0, 32'(c));
        repeat (SETTLE + 40) @(posedge clk);
        axi_read(ADDR_STATUS, 32'h1 << STS_SETTLED, 32'h1 << STS_SETTLED, RESP_OKAY);
        check_val("active", 32'h1, 32'(converter_active));
        count_words(c);
        check_val("wake rate", 32'd20, 32'(c));
        word_check(14'h1234, 14'h3234);
        final_report;
    end

    // watchdog well beyond the expected run length
    initial
    begin
        repeat (20000) @(posedge clk);
        num_errors++;
        final_report;
    end
endmodule

//--- verif/aom_capture_model.sv
`timescale 1ns/100ps
module aom_capture_model
    import aom_pkg::*;
(
    input wire logic word_valid_strobe,
    input wire logic [aom_pkg::WORD_W-1:0] sample_word,
    output logic [aom_pkg::WORD_W-1:0] held_word,
    output int word_count
);
    // nothing captured yet
    initial
    begin
        held_word = '0;
        word_count = 0;
    end

    // latch on strobe
    // words without a strobe are never trusted, so sleep output is ignored
    always @(posedge word_valid_strobe)
    begin
        held_word <= sample_word;
        word_count <= word_count + 1;
    end
endmodule

//--- verif/aom_checker.sv
`timescale 1ns/100ps
module aom_checker
    import aom_pkg::*;
#(
    parameter int PIPE_STAGES = aom_pkg::PIPE_DEPTH
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic clk_en,
    input wire logic sample_clk,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic sleep_request,
    input wire logic [1:0] format_stabiliser_select,
    input wire logic [aom_pkg::WORD_W-1:0] raw_code,
    input wire logic [aom_pkg::WORD_W-1:0] sample_word,
    input wire logic word_valid_strobe,
    input wire logic duty_stabiliser,
    input wire logic converter_active
);
    // sample clock rises from a raw code being taken to its strobed word
    localparam int LAT = PIPE_STAGES + 1;
    // decoded select levels
    wire sel_dcs = format_stabiliser_select == SEL_ONE_THIRD ||
                   format_stabiliser_select == SEL_TWO_THIRDS;
    wire sel_twos = format_stabiliser_select[1];

    // windows of 8 cover the reset crossing and the 2-flop select sync
    dcs_off_a: assert property (
        @(posedge sample_clk) disable iff (srst) (!sel_dcs) [*8] |=> !duty_stabiliser)
        else $error("stabiliser on for an unstabilised select");
    dcs_on_a: assert property (
        @(posedge sample_clk) disable iff (srst) sel_dcs [*8] |=> duty_stabiliser)
        else $error("stabiliser off for a stabilised select");
    // extra past depth keeps a select change inside the pipe out of the check
    twos_word_a: assert property (
        @(posedge sample_clk) disable iff (srst)
        word_valid_strobe && sel_twos && $past(sel_twos, LAT) && $past(sel_twos, LAT + 4)
        |-> sample_word == ($past(raw_code, LAT) ^ 14'h2000))
        else $error("twos complement word wrong");
    offset_word_a: assert property (
        @(posedge sample_clk) disable iff (srst)
        word_valid_strobe && !sel_twos && !$past(sel_twos, LAT) && !$past(sel_twos, LAT + 4)
        |-> sample_word == $past(raw_code, LAT))
        else $error("offset binary word wrong");
    sleep_follow_a: assert property (
        @(posedge clk) disable iff (srst) (sleep_request && clk_en) [*6] |-> !converter_active)
        else $error("converter active while sleep held");
    sleep_quiet_a: assert property (
        @(posedge sample_clk) disable iff (srst) (!converter_active) [*4] |-> !word_valid_strobe)
        else $error("strobe while asleep");
    // the strobe drops at every rising edge, so one rise per word
    strobe_drop_a: assert property (
        @(negedge sample_clk) disable iff (srst) !word_valid_strobe)
        else $error("strobe not low before falling edge");
    write_answer_a: assert property (
        @(posedge clk) disable iff (srst) clk_en && !s_axi_bvalid && s_axi_awvalid &&
        s_axi_awready && s_axi_wvalid && s_axi_wready ##1 clk_en |=> s_axi_bvalid)
        else $error("write response late");
    read_answer_a: assert property (
        @(posedge clk) disable iff (srst) clk_en && s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid)
        else $error("read data late");
    read_hold_a: assert property (
        @(posedge clk) disable iff (srst) s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("read data dropped before taken");

    // main scenarios reached
    cover property (@(posedge sample_clk) word_valid_strobe && duty_stabiliser);
    cover property (@(posedge clk) sleep_request && !converter_active);
    cover property (@(posedge clk) s_axi_rvalid && !s_axi_rready);
endmodule

bind aom_top aom_checker #(.PIPE_STAGES(PIPE_STAGES)) u_aom_checker (
    .clk, .srst, .clk_en, .sample_clk, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rready, .sleep_request, .format_stabiliser_select, .raw_code, .sample_word,
    .word_valid_strobe, .duty_stabiliser, .converter_active
);
